// >>> design/pcs_defines.svh
// constants for the gigabit pcs datapath
`ifndef PCS_DEFINES_SVH
`define PCS_DEFINES_SVH
`define APB_CTRL 12'h000
`define APB_STATUS 12'h004
`define CTRL_SPEED_RST 2'h0
`define CG_K285 8'hbc
`define CG_D162 8'h50
`define CG_S 8'hfb
`define CG_T 8'hfd
`define CG_R 8'hf7
`define CG_V 8'hfe
`define CG_PRE 8'h55
`define REP_1G 7'h01
`define REP_100M 7'h0a
`define REP_10M 7'h64
`define TH_LO_1G 11'h010
`define TH_HI_1G 11'h020
`define TH_LO_100M 11'h022
`define TH_HI_100M 11'h044
`define TH_LO_10M 11'h154
`define TH_HI_10M 11'h280
`define FIFO_CTC_DEPTH 1024
`define FIFO_NONE_DEPTH 16
`define SYNC_COMMAS 3'h3
`define SYNC_BAD_MAX 3'h4
`define LOSS_LIMIT 32'h00002710
`endif

// >>> design/pcs_pkg.sv
// types and helpers shared by the pcs datapath
package pcs_pkg;
  `include "pcs_defines.svh"
  typedef enum logic [1:0] {speed_1g, speed_100m, speed_10m} speed_e;
  typedef enum logic [1:0] {ctc_dynamic, ctc_static, ctc_none} ctc_mode_e;
  typedef enum {tx_idle_k, tx_idle_d, tx_data, tx_tail} tx_state_e;
  typedef enum {sync_lost, sync_acq, sync_ok} sync_state_e;
  typedef enum {rx_idle, rx_frame} rx_state_e;
  typedef struct packed {
    logic mode_sgmii;
    logic code_err;
    logic code_k;
    logic [7:0] code;
    logic tx_er;
    logic tx_en;
    logic [7:0] txd;
    logic loc_clk;
    logic rec_clk;
    logic byte_clk;
    logic gtx_clk;
  } pin_s;

  function automatic logic [6:0] reps(speed_e s);
    case (s)
      speed_100m: reps = `REP_100M;
      speed_10m: reps = `REP_10M;
      default: reps = `REP_1G;
    endcase
  endfunction
endpackage

// >>> design/rx_fifo_if.sv
// link between the receive core and the rate match fifo
`timescale 1ns/1ps
`default_nettype none
interface rx_fifo_if;
  logic wr_stb;
  logic [8:0] wr_data;
  logic rd_stb;
  logic [8:0] rd_data;
  logic rd_valid;
  logic [10:0] level;
  pcs_pkg::speed_e speed;
  modport core(output wr_stb, wr_data, rd_stb, speed,
               input rd_data, rd_valid, level);
  modport buffer(input wr_stb, wr_data, rd_stb, speed,
                 output rd_data, rd_valid, level);
endinterface
`default_nettype wire

// >>> design/rx_rate_match_fifo.sv
// receive clock tolerance fifo with idle insertion and deletion
`timescale 1ns/1ps
`default_nettype none
module rx_rate_match_fifo #(
  parameter pcs_pkg::ctc_mode_e MODE = pcs_pkg::ctc_dynamic,
  parameter logic [10:0] STATIC_LOW = `TH_LO_1G,
  parameter logic [10:0] STATIC_HIGH = `TH_HI_1G
) (
  input wire logic pclk,
  input wire logic presetn,
  rx_fifo_if.buffer f
);
  import pcs_pkg::*;
  // none mode only needs a shallow crossing buffer
  localparam int DEPTH = (MODE == ctc_none) ?
    `FIFO_NONE_DEPTH : `FIFO_CTC_DEPTH; // [RQ5] [RQ11]
  localparam int AW = $clog2(DEPTH);

  logic [8:0] mem [DEPTH];
  logic [AW:0] wp;
  logic [AW:0] rp;
  logic wr_prev_k, wr_ipg, rd_prev_k, rd_ipg, drop;
  logic [1:0] ins_cnt;

  wire ctc_on = (MODE != ctc_none); // [RQ10]
  wire [AW:0] fill = wp - rp;
  wire [10:0] fill11 = 11'(fill);
  wire full = (fill11 == 11'(DEPTH));
  wire empty = (fill == '0);
  wire [8:0] head = mem[rp[AW-1:0]];
  wire wr_k = (f.wr_data == {1'b1, `CG_K285});
  wire wr_d = (f.wr_data == {1'b0, `CG_D162});
  // dynamic follows the rate, static is frozen at build time
  wire [10:0] low_th = (MODE == ctc_static) ? STATIC_LOW : // [RQ9]
    (f.speed == speed_10m) ? `TH_LO_10M :
    (f.speed == speed_100m) ? `TH_LO_100M : `TH_LO_1G; // [RQ8]
  wire [10:0] high_th = (MODE == ctc_static) ? STATIC_HIGH :
    (f.speed == speed_10m) ? `TH_HI_10M :
    (f.speed == speed_100m) ? `TH_HI_100M : `TH_HI_1G; // [RQ8]

  // deletion: drop a whole /K/ /D/ pair so alignment survives
  wire start_drop = ctc_on && f.wr_stb && wr_k && wr_ipg &&
    (fill11 > high_th) && !drop; // [RQ7]
  wire do_wr = f.wr_stb && !start_drop && !drop && !full;

  wire start_ins = ctc_on && f.rd_stb && ins_cnt == 2'h0 && rd_ipg &&
    (fill11 < low_th) && (empty || head == {1'b1, `CG_K285}); // [RQ6]
  wire inserting = start_ins || ins_cnt != 2'h0;
  wire do_rd = f.rd_stb && !inserting && !empty;
  wire [8:0] ins_byte = (start_ins || ins_cnt == 2'h2) ?
    {1'b1, `CG_K285} : {1'b0, `CG_D162};
  wire [8:0] out_byte = inserting ? ins_byte : head;
  wire out_k = (out_byte == {1'b1, `CG_K285});
  wire out_d = (out_byte == {1'b0, `CG_D162});

  always_ff @(posedge pclk) begin
    if (do_wr) begin
      mem[wp[AW-1:0]] <= f.wr_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp <= '0;
      wr_prev_k <= 1'b0;
      wr_ipg <= 1'b0;
      drop <= 1'b0;
    end else if (f.wr_stb) begin
      wp <= do_wr ? wp + 1'b1 : wp;
      drop <= start_drop; // [RQ7]
      wr_prev_k <= wr_k;
      wr_ipg <= (wr_prev_k && wr_d) || (wr_k && wr_ipg);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rp <= '0;
      ins_cnt <= 2'h0;
      rd_prev_k <= 1'b0;
      rd_ipg <= 1'b0;
      f.rd_data <= 9'h000;
      f.rd_valid <= 1'b0;
      f.level <= 11'h000;
    end else begin
      f.level <= fill11;
      f.rd_valid <= f.rd_stb && (inserting || do_rd);
      if (f.rd_stb && (inserting || do_rd)) begin
        f.rd_data <= out_byte;
        rd_prev_k <= out_k;
        rd_ipg <= (rd_prev_k && out_d) || (out_k && rd_ipg);
      end
      if (do_rd) begin
        rp <= rp + 1'b1;
      end
      if (start_ins) begin
        ins_cnt <= 2'h3; // [RQ6]
      end else if (f.rd_stb && ins_cnt != 2'h0) begin
        ins_cnt <= ins_cnt - 2'h1;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ins;
    start_ins |=> (ins_cnt == 2'h3 && $stable(rp));
  endproperty
  a_ins: assert property (p_ins) else $error("insert did not halt reads"); // [RQ6]
  property p_drop;
    start_drop |=> (drop && $stable(wp));
  endproperty
  a_drop: assert property (p_drop) else $error("drop did not block"); // [RQ7]
  property p_none;
    !ctc_on |-> (fill11 <= 11'h010 && !start_ins && !start_drop);
  endproperty
  a_none: assert property (p_none) else $error("none mode misbehaved"); // [RQ11]
  c_ins: cover property (start_ins);
  c_drop: cover property (start_drop);
endmodule
`default_nettype wire

// >>> design/gigabit_pcs_datapath.sv
// gigabit / sgmii pcs datapath: rate adaptation, tx/rx machines, sync
// Notes on behaviour
// RQ1: 1g transmit passes bytes through unchanged
// RQ2: 100m transmit joins nibbles, repeats each byte ten
// RQ3: 10m transmit repeats each byte one hundred times
// RQ4: transmit emits 8-bit code groups plus k flag
// RQ5: receive crosses domains through 1024-byte watermark fifo
// RQ6: low fill in gap inserts two idle-2 sets
// RQ7: high fill in gap blocks one idle set
// RQ8: dynamic mode thresholds follow the current rate
// RQ9: static mode thresholds are build parameters
// RQ10: compensation mode is a build-time parameter
// RQ11: none mode uses a plain 16-byte fifo
// RQ12: none mode needs equal-frequency receive clocks
// RQ13: only aligned code groups reach the receiver
// RQ14: long alignment loss requests negotiation restart
// RQ15: receive machine turns code groups into frames
// RQ16: receive output rate divided by 1, 10, 100
// RQ17: external pin picks sgmii or 1000base-x
// RQ18: receive keeps one byte per ten/hundred, as nibbles
`timescale 1ns/1ps
`default_nettype none
module gigabit_pcs_datapath #(
  parameter pcs_pkg::ctc_mode_e CTC_MODE = pcs_pkg::ctc_dynamic,
  parameter logic [10:0] STATIC_LOW = `TH_LO_1G,
  parameter logic [10:0] STATIC_HIGH = `TH_HI_1G,
  parameter logic [31:0] LOSS_LIMIT = `LOSS_LIMIT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic gmii_tx_clk,
  input wire logic [7:0] gmii_txd,
  input wire logic gmii_tx_en,
  input wire logic gmii_tx_er,
  input wire logic tx_byte_clk,
  output logic [7:0] tx_code,
  output logic tx_code_k,
  output logic tx_code_stb,
  input wire logic rx_rec_clk,
  input wire logic [7:0] rx_code,
  input wire logic rx_code_k,
  input wire logic rx_code_err,
  input wire logic rx_local_clk,
  output logic [7:0] gmii_rxd,
  output logic gmii_rx_dv,
  output logic gmii_rx_er,
  output logic gmii_rx_strobe,
  input wire logic mode_sgmii,
  output logic link_sync,
  output logic an_restart
);
  import pcs_pkg::*;

  pin_s pins, s1, s2;
  logic [3:0] clk_d;
  assign pins = {mode_sgmii, rx_code_err, rx_code_k, rx_code, gmii_tx_er,
                 gmii_tx_en, gmii_txd, rx_local_clk, rx_rec_clk,
                 tx_byte_clk, gmii_tx_clk};
  wire [3:0] clk_now = {s2.loc_clk, s2.rec_clk, s2.byte_clk, s2.gtx_clk};
  wire [3:0] rise = clk_now & ~clk_d;
  wire tx_in_stb = rise[0];
  wire tx_out_stb = rise[1];
  wire rec_stb = rise[2];
  wire local_stb = rise[3];

  // every pin packed into pins, data included, goes through two stages first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= '0;
      s2 <= '0;
      clk_d <= 4'h0;
    end else begin
      s1 <= pins;
      s2 <= s1;
      clk_d <= clk_now;
    end
  end

  // register slave
  logic [1:0] ctrl_speed;
  logic [7:0] rxb;
  logic rxb_dv, rxb_er, rxb_stb;
  rx_state_e rx_st;
  rx_fifo_if fif();
  wire speed_e speed = (ctrl_speed == 2'h3) ? speed_1g : speed_e'(ctrl_speed);
  wire [6:0] rep_n = reps(speed);
  wire setup = psel && !penable;
  wire hit_ctrl = (paddr == `APB_CTRL);
  wire hit_stat = (paddr == `APB_STATUS);
  wire [31:0] status_word = {5'h00, fif.level, 13'h0000,
    rx_st == rx_frame, s2.mode_sgmii, link_sync}; // [RQ17]
  wire [31:0] rd_mux = hit_ctrl ? {30'h0, ctrl_speed} :
                       hit_stat ? status_word : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
      ctrl_speed <= `CTRL_SPEED_RST;
    end else begin
      pready <= setup;
      prdata <= (setup && !pwrite) ? rd_mux : 32'h0;
      pslverr <= setup && !(hit_ctrl || hit_stat);
      if (psel && penable && pready && pwrite && hit_ctrl) begin
        ctrl_speed <= pwdata[1:0];
      end
    end
  end

  // transmit rate adaptation
  logic [3:0] nib_lo;
  logic nib_hi;
  logic [7:0] tb, cur;
  logic tb_en, tb_er, cur_en, cur_er;
  logic [6:0] rep_left;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {nib_lo, nib_hi, tb, tb_en, tb_er} <= '0;
    end else if (tx_in_stb) begin
      if (speed == speed_1g) begin
        {tb, tb_en, tb_er} <= {s2.txd, s2.tx_en, s2.tx_er}; // [RQ1]
      end else if (!nib_hi && s2.tx_en) begin
        nib_lo <= s2.txd[3:0];
        nib_hi <= 1'b1;
      end else begin
        // low nibble first, as the mac sends it
        tb <= {s2.txd[3:0], nib_lo}; // [RQ2] [RQ3]
        {tb_en, tb_er} <= {s2.tx_en, s2.tx_er};
        nib_hi <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {cur, cur_en, cur_er} <= '0;
      rep_left <= 7'h00;
    end else if (tx_out_stb) begin
      if (rep_left == 7'h00) begin
        {cur, cur_en, cur_er} <= {tb, tb_en, tb_er};
        rep_left <= rep_n - 7'h01; // [RQ2] [RQ3]
      end else begin
        rep_left <= rep_left - 7'h01;
      end
    end
  end

  // transmit code-group machine; /S/ only lands on an even slot
  tx_state_e tx_st, next_tx_st;
  logic tx_odd;
  logic [7:0] next_code;
  logic next_k;
  always_comb begin
    next_tx_st = tx_st;
    next_code = `CG_D162;
    next_k = 1'b0;
    unique case (tx_st)
      tx_idle_k: begin
        next_k = 1'b1;
        next_code = cur_en ? `CG_S : `CG_K285;
        next_tx_st = cur_en ? tx_data : tx_idle_d;
      end
      tx_idle_d: next_tx_st = tx_idle_k;
      tx_data: begin
        next_k = !cur_en || cur_er;
        next_code = !cur_en ? `CG_T : cur_er ? `CG_V : cur;
        next_tx_st = cur_en ? tx_data : tx_tail;
      end
      tx_tail: begin
        next_k = 1'b1;
        next_code = `CG_R;
        next_tx_st = tx_odd ? tx_idle_k : tx_tail;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st <= tx_idle_k;
      tx_odd <= 1'b0;
      tx_code <= 8'h00;
      tx_code_k <= 1'b0;
      tx_code_stb <= 1'b0;
    end else begin
      tx_code_stb <= tx_out_stb;
      if (tx_out_stb) begin
        tx_st <= next_tx_st;
        tx_odd <= !tx_odd;
        tx_code <= next_code; // [RQ4]
        tx_code_k <= next_k;
      end
    end
  end

  // synchronization
  sync_state_e sync_st;
  logic [2:0] sync_cnt;
  logic [31:0] loss_cnt;
  wire [8:0] rx_cg = {s2.code_k, s2.code};
  wire comma = (rx_cg == {1'b1, `CG_K285});

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_st <= sync_lost;
      sync_cnt <= 3'h0;
    end else if (rec_stb) begin
      unique case (sync_st)
        sync_lost: if (comma) begin
          sync_st <= sync_acq;
          sync_cnt <= 3'h1;
        end
        sync_acq: if (s2.code_err) begin
          sync_st <= sync_lost;
        end else if (comma) begin
          sync_cnt <= sync_cnt + 3'h1;
          if (sync_cnt == `SYNC_COMMAS - 3'h1) begin
            sync_st <= sync_ok; // [RQ13]
            sync_cnt <= 3'h0;
          end
        end
        sync_ok: if (!s2.code_err) begin
          sync_cnt <= 3'h0;
        end else if (sync_cnt == `SYNC_BAD_MAX - 3'h1) begin
          sync_st <= sync_lost;
          sync_cnt <= 3'h0;
        end else begin
          sync_cnt <= sync_cnt + 3'h1;
        end
      endcase
    end
  end

  // loss is timed in pclk cycles so a dead recovered clock still counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loss_cnt <= 32'h0;
      an_restart <= 1'b0;
      link_sync <= 1'b0;
    end else begin
      link_sync <= (sync_st == sync_ok);
      an_restart <= 1'b0;
      if (sync_st == sync_ok) begin
        loss_cnt <= 32'h0;
      end else if (loss_cnt == LOSS_LIMIT - 32'h1) begin
        loss_cnt <= 32'h0;
        an_restart <= 1'b1; // [RQ14]
      end else begin
        loss_cnt <= loss_cnt + 32'h1;
      end
    end
  end

  assign fif.wr_stb = rec_stb && sync_st == sync_ok; // [RQ13]
  assign fif.wr_data = rx_cg;
  assign fif.rd_stb = local_stb;
  assign fif.speed = speed;

  rx_rate_match_fifo #(
    .MODE(CTC_MODE),
    .STATIC_LOW(STATIC_LOW),
    .STATIC_HIGH(STATIC_HIGH)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .f(fif.buffer)
  );

  // receive machine
  wire [8:0] rb = fif.rd_data;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st <= rx_idle;
      {rxb, rxb_dv, rxb_er, rxb_stb} <= '0;
    end else begin
      rxb_stb <= fif.rd_valid;
      if (fif.rd_valid) begin
        unique case (rx_st)
          rx_idle: begin
            rxb_er <= 1'b0;
            rxb_dv <= (rb == {1'b1, `CG_S});
            rxb <= (rb == {1'b1, `CG_S}) ? `CG_PRE : 8'h00; // [RQ15]
            rx_st <= (rb == {1'b1, `CG_S}) ? rx_frame : rx_idle;
          end
          rx_frame: if (!rb[8]) begin
            {rxb, rxb_dv, rxb_er} <= {rb[7:0], 2'b10}; // [RQ15]
          end else if (rb[7:0] == `CG_T || rb[7:0] == `CG_K285) begin
            // a comma inside a frame ends it as bad
            rxb_dv <= 1'b0;
            rxb_er <= (rb[7:0] == `CG_K285);
            rx_st <= rx_idle;
          end else begin
            {rxb_dv, rxb_er} <= 2'b11;
          end
        endcase
      end
    end
  end

  // receive rate adaptation
  logic [6:0] rcnt;
  logic [3:0] rx_hi;
  wire [6:0] half = rep_n >> 1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {rcnt, rx_hi, gmii_rxd, gmii_rx_dv, gmii_rx_er} <= '0;
      gmii_rx_strobe <= 1'b0;
    end else begin
      gmii_rx_strobe <= 1'b0;
      if (rxb_stb && speed == speed_1g) begin
        {gmii_rxd, gmii_rx_dv, gmii_rx_er} <= {rxb, rxb_dv, rxb_er};
        gmii_rx_strobe <= 1'b1; // [RQ16]
      end else if (rxb_stb) begin
        rcnt <= (rcnt >= rep_n - 7'h01) ? 7'h00 : rcnt + 7'h01;
        if (rcnt == 7'h00) begin
          {gmii_rxd, gmii_rx_dv, gmii_rx_er} <= {4'h0, rxb[3:0], rxb_dv, rxb_er};
          rx_hi <= rxb[7:4];
          gmii_rx_strobe <= 1'b1; // [RQ16] [RQ18]
        end else if (rcnt == half) begin
          gmii_rxd <= {4'h0, rx_hi}; // [RQ18]
          gmii_rx_strobe <= 1'b1;
        end
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_tx_1g;
    (tx_in_stb && speed == speed_1g) |=> (tb == $past(s2.txd));
  endproperty
  a_tx_1g: assert property (p_tx_1g) else $error("1g byte altered"); // [RQ1]
  property p_rep_100m;
    (tx_out_stb && rep_left == 7'h00 && speed == speed_100m)
      |=> (rep_left == 7'h09);
  endproperty
  a_rep_100m: assert property (p_rep_100m) else $error("100m repeat"); // [RQ2]
  property p_rep_10m;
    (tx_out_stb && rep_left == 7'h00 && speed == speed_10m)
      |=> (rep_left == 7'h63);
  endproperty
  a_rep_10m: assert property (p_rep_10m) else $error("10m repeat"); // [RQ3]
  property p_tx_k;
    tx_code_k |-> (tx_code inside {`CG_K285, `CG_S, `CG_T, `CG_R, `CG_V});
  endproperty
  a_tx_k: assert property (p_tx_k) else $error("bad k code"); // [RQ4]
  property p_sync;
    (rec_stb && sync_st == sync_lost) |=> (sync_st != sync_ok);
  endproperty
  a_sync: assert property (p_sync) else $error("sync too fast"); // [RQ13]
  property p_restart;
    an_restart |-> ($past(sync_st) != sync_ok && !link_sync);
  endproperty
  a_restart: assert property (p_restart) else $error("bad restart"); // [RQ14]
  property p_rx_sop;
    (fif.rd_valid && rx_st == rx_idle && rb == {1'b1, `CG_S})
      |=> (rxb_stb && rxb_dv && rxb == `CG_PRE);
  endproperty
  a_rx_sop: assert property (p_rx_sop) else $error("no frame start"); // [RQ15]
  property p_rx_1g;
    (rxb_stb && speed == speed_1g)
      |=> (gmii_rx_strobe && gmii_rxd == $past(rxb));
  endproperty
  a_rx_1g: assert property (p_rx_1g) else $error("1g rx altered"); // [RQ16]
  property p_rx_nib;
    (rxb_stb && speed != speed_1g && rcnt == 7'h00)
      |=> (gmii_rx_strobe && gmii_rxd[7:4] == 4'h0);
  endproperty
  a_rx_nib: assert property (p_rx_nib) else $error("nibble out"); // [RQ18]
  c_tx_frame: cover property (tx_st == tx_data);
  c_sync: cover property ($rose(link_sync));
  c_rx_frame: cover property (gmii_rx_strobe && gmii_rx_dv);
endmodule
`default_nettype wire

// >>> dv/pcs_far_model.sv
// far-side model: shared link clock and the serdes receive code stream
`timescale 1ns/1ps
`default_nettype none
module pcs_far_model (
  input wire logic [8:0] sym,
  input wire logic sym_err,
  output logic link_clk,
  output logic [7:0] rx_code,
  output logic rx_code_k,
  output logic rx_code_err
);
  // one clock feeds recovered and local sides: equal frequency, same phase
  // the symbol outputs have a single driver; they settle before reset ends
  initial begin
    link_clk = 1'b0;
    forever #32 link_clk = ~link_clk;
  end
  // change on the falling edge so the sampled rise sees a settled symbol
  always @(negedge link_clk) begin
    rx_code <= sym[7:0];
    rx_code_k <= sym[8];
    rx_code_err <= sym_err;
  end
endmodule
`default_nettype wire

// >>> dv/tb.sv
// self-checking bench for the pcs datapath
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pcs_pkg::*;
  typedef struct packed {
    logic wr; logic [11:0] a; logic [31:0] d; logic [31:0] q; logic e;
  } row_s;
  localparam row_s ROWS [7] = '{
    {1'b0, 12'h000, 32'h0, 32'h0, 1'b0}, {1'b1, 12'h000, 32'h2, 32'h0, 1'b0},
    {1'b0, 12'h000, 32'h0, 32'h2, 1'b0}, {1'b1, 12'h004, 32'hffff, 32'h0, 1'b0},
    {1'b0, 12'h008, 32'h0, 32'h0, 1'b1}, {1'b1, 12'h000, 32'h0, 32'h0, 1'b0},
    {1'b0, 12'h000, 32'h0, 32'h0, 1'b0}};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, lclk;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [8:0] sym;
  logic [7:0] rx_code, tx_code, gmii_rxd, gmii_txd;
  logic rx_code_k, rx_code_err, tx_code_k, tx_code_stb, sym_err, mode_sgmii;
  logic gmii_tx_en, gmii_tx_er, gmii_rx_dv, gmii_rx_er, gmii_rx_strobe;
  logic link_sync, an_restart, er;
  logic tx_count, lclk_q;
  logic [7:0] tx_byte;
  logic [7:0] got[$];
  int num_errors, num_checks, n, len;
  int reps_exp [3] = '{1, 10, 100};

  gigabit_pcs_datapath #(.LOSS_LIMIT(32'h00000032)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .gmii_tx_clk(lclk),
    .gmii_txd(gmii_txd), .gmii_tx_en(gmii_tx_en), .gmii_tx_er(gmii_tx_er),
    .tx_byte_clk(lclk), .tx_code(tx_code), .tx_code_k(tx_code_k),
    .tx_code_stb(tx_code_stb), .rx_rec_clk(lclk), .rx_code(rx_code),
    .rx_code_k(rx_code_k), .rx_code_err(rx_code_err), .rx_local_clk(lclk),
    .gmii_rxd(gmii_rxd), .gmii_rx_dv(gmii_rx_dv), .gmii_rx_er(gmii_rx_er),
    .gmii_rx_strobe(gmii_rx_strobe), .mode_sgmii(mode_sgmii),
    .link_sync(link_sync), .an_restart(an_restart));
  pcs_far_model far (.sym(sym), .sym_err(sym_err), .link_clk(lclk),
    .rx_code(rx_code), .rx_code_k(rx_code_k), .rx_code_err(rx_code_err));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (gmii_rx_strobe === 1'b1 && gmii_rx_dv === 1'b1) got.push_back(gmii_rxd);
  end

  // mac byte source: holds or counts, changed just after a link clock fall
  always @(posedge pclk) begin
    lclk_q <= lclk;
    if (lclk_q && !lclk) gmii_txd <= tx_count ? gmii_txd + 8'h01 : tx_byte;
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, got_v);
    num_checks++;
    if (got_v !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got_v);
    end
  endtask

  function automatic logic pick(input int w);
    case (w)
      0: pick = link_sync;
      1: pick = an_restart;
      2: pick = ~link_sync;
      default: pick = tx_code_stb;
    endcase
  endfunction

  // bounded wait; running out counts a mismatch and closes the run
  task automatic wait_for(input int w, input int lim, output int k);
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pick(w) !== 1'b1 && k < lim);
    if (k >= lim) begin
      check("wait", 1, 0);
      give_verdict;
    end
  endtask

  task automatic apb(input row_s r, output logic [31:0] q, output logic e);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= r.wr;
    paddr <= r.a;
    pwdata <= r.d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 40);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 40) begin
      check("pready", 1, 0);
      give_verdict;
    end
  endtask

  task automatic send(input logic [8:0] s);
    @(posedge lclk);
    @(posedge pclk);
    sym <= s;
  endtask

  task automatic idles(input int k);
    repeat (k) begin
      send({1'b1, 8'hbc});
      send({1'b0, 8'h50});
    end
  endtask

  task automatic next_code(input logic [7:0] want);
    int k;
    k = 0;
    do begin
      wait_for(3, 400, n);
      k++;
    end while ((tx_code !== want || tx_code_k !== 1'b1) && k < 400);
    check("next code", {1'b1, want}, {tx_code_k, tx_code});
  endtask

  // strobes for which the current code group stands unchanged
  task automatic run_len(output int k);
    logic [8:0] v;
    v = {tx_code_k, tx_code};
    k = 0;
    do begin
      wait_for(3, 400, n);
      k++;
    end while ({tx_code_k, tx_code} === v && k < 300);
  endtask

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {gmii_tx_en, gmii_tx_er, sym_err, tx_count} = '0;
    tx_byte = 8'ha5;
    sym = {1'b0, 8'h50};
    mode_sgmii = 1'b1;
    num_errors = 0;
    num_checks = 0;
    repeat (15) @(posedge pclk);
    check("pready in reset", 0, pready);
    check("tx_code_stb in reset", 0, tx_code_stb);
    @(posedge pclk);
    presetn <= 1'b1;
    foreach (ROWS[i]) begin
      apb(ROWS[i], rd, er);
      check("prdata", ROWS[i].q, rd);
      check("pslverr", ROWS[i].e, er);
    end
    $display("test registers done");

    idles(4);
    wait_for(0, 600, n);
    apb({1'b0, 12'h004, 32'h0, 32'h0, 1'b0}, rd, er);
    check("status sync", 1, rd[0]);
    check("status mode", 1, rd[1]);
    mode_sgmii <= 1'b0;
    repeat (4) @(posedge pclk);
    apb({1'b0, 12'h004, 32'h0, 32'h0, 1'b0}, rd, er);
    check("status mode low", 0, rd[1]);
    idles(40);
    send({1'b1, 8'hfb});
    send({1'b0, 8'ha5});
    send({1'b0, 8'h3c});
    send({1'b1, 8'hfd});
    send({1'b1, 8'hf7});
    idles(20);
    check("rx bytes", 3, got.size());
    if (got.size() == 3) begin
      check("rx preamble", 8'h55, got[0]);
      check("rx data0", 8'ha5, got[1]);
      check("rx data1", 8'h3c, got[2]);
    end
    check("rx er", 0, gmii_rx_er);
    $display("test receive done");

    // idle is made after replication, so only frame data shows the repeats;
    // a counting source gives every replicated byte a run of its own
    for (int s = 0; s < 3; s++) begin
      apb({1'b1, 12'h000, 32'(s), 32'h0, 1'b0}, rd, er);
      tx_count <= 1'b1;
      gmii_tx_en <= 1'b1;
      next_code(8'hfb);
      // skip the start code and the partly used first byte
      repeat (3) run_len(len);
      check("repeat count", reps_exp[s], len);
      tx_count <= 1'b0;
      gmii_tx_en <= 1'b0;
      next_code(8'hfd);
      wait_for(3, 400, n);
      check("tail code", {1'b1, 8'hf7}, {tx_code_k, tx_code});
    end
    $display("test repeat done");

    apb(ROWS[5], rd, er);
    @(posedge pclk);
    gmii_tx_en <= 1'b1;
    next_code(8'hfb);
    check("start code", {1'b1, 8'hfb}, {tx_code_k, tx_code});
    wait_for(3, 400, n);
    check("tx data", {1'b0, 8'ha5}, {tx_code_k, tx_code});
    gmii_tx_en <= 1'b0;
    next_code(8'hfd);
    check("end code", {1'b1, 8'hfd}, {tx_code_k, tx_code});
    $display("test transmit done");

    @(posedge pclk);
    sym_err <= 1'b1;
    wait_for(2, 600, n);
    wait_for(1, 200, n);
    check("restart delay", 1, 32'(n >= 45 && n <= 60));
    $display("test restart done");
    give_verdict;
  end
endmodule
`default_nettype wire
